/* File: rtl/psq_map.vh */
// Register map, field positions, reset values and codes of the pressure sample queue.
// Assumes it is included by bare name from the queue design file only.
`ifndef PSQ_MAP_VH
`define PSQ_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PSQ_ADDR_CONTROL_TWO     7'h21
`define PSQ_ADDR_CONTROL_THREE   7'h22
`define PSQ_ADDR_CONTROL_FOUR    7'h23
`define PSQ_ADDR_PRESS_LOWEST    7'h28
`define PSQ_ADDR_PRESS_MIDDLE    7'h29
`define PSQ_ADDR_PRESS_UPPER     7'h2A
`define PSQ_ADDR_QUEUE_CONTROL   7'h2E
`define PSQ_ADDR_QUEUE_STATUS    7'h2F

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PSQ_C2_QUEUE_ON          6
`define PSQ_C2_THRESHOLD_ON      5
`define PSQ_C2_DECIMATE_ON       4
`define PSQ_C3_ACTIVE_LOW        7
`define PSQ_C4_ROUTE_READY       0
`define PSQ_C4_ROUTE_THRESHOLD   1
`define PSQ_C4_ROUTE_FULL        2
`define PSQ_C4_ROUTE_EMPTY       3
`define PSQ_QC_MODE_HI           7
`define PSQ_QC_MODE_LO           5
`define PSQ_QC_LEVEL_HI          4
`define PSQ_QC_LEVEL_LO          0
`define PSQ_QS_THRESHOLD         7
`define PSQ_QS_EMPTY             6

// ----------------------------------------------------------------------------
// Reset values and behaviour codes
// ----------------------------------------------------------------------------
`define PSQ_RST_BYTE             8'h00
`define PSQ_MODE_BYPASS          3'h0
`define PSQ_MODE_FILL_STOP       3'h1
`define PSQ_MODE_STREAM          3'h2
`define PSQ_MODE_AVERAGE         3'h6

`endif

/* File: rtl/psq_queue.v */
// Pressure sample queue with register file, averaging filter and calibration load.
// Assumes a serial port front end that turns host accesses into single-cycle
// register read and write strobes, and a measurement chain giving sample pulses.
`timescale 1ns/10ps
`include "psq_map.vh"

module psq_queue #(
    parameter DEPTH = 32,     // Queue slots.
    parameter PTR_W = 5,      // Pointer width, log2 of DEPTH.
    parameter CAL_WORDS = 8   // Calibration words loaded after reset.
) (
    input wire clock,                         // System clock, 50 MHz.
    input wire reset_n,                       // Asynchronous reset, active low.
    input wire [6:0] reg_addr,                // Register address from serial port.
    input wire reg_wr,                        // Register write strobe.
    input wire [7:0] reg_wdata,               // Register write data.
    input wire reg_rd,                        // Register read strobe.
    output reg [7:0] reg_rdata,               // Register read data, one cycle late.
    input wire sample_valid,                  // New pressure and temperature pair.
    input wire [23:0] sample_press,           // Pressure result.
    output reg [2:0] nvm_addr,                // Calibration store address.
    input wire [7:0] nvm_data,                // Calibration store data for nvm_addr.
    output reg calib_done,                    // Calibration copy finished.
    output reg [CAL_WORDS*8-1:0] trim_words,  // Working calibration registers.
    output reg data_ready,                    // New result not yet read.
    output reg interrupt_pin                  // Interrupt output.
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    localparam CAL_LOAD = 2'b01;
    localparam CAL_RUN = 2'b10;
    localparam [PTR_W:0] DEPTH_L = DEPTH;

    reg [23:0] mem [0:DEPTH-1];
    reg [1:0] cal_state_r;
    reg [7:0] control_two_r;
    reg [7:0] control_three_r;
    reg [7:0] control_four_r;
    reg [7:0] queue_control_r;
    reg [PTR_W-1:0] wr_ptr_r;
    reg [PTR_W-1:0] rd_ptr_r;
    reg [PTR_W:0] level_r;
    reg [PTR_W:0] level_nxt;
    reg [23:0] out_hold_r;
    reg [PTR_W+24:0] sum_r;
    reg [PTR_W+24:0] sum_nxt;
    reg [2:0] shift_nxt;
    reg [7:0] rdata_nxt;
    wire [2:0] mode = queue_control_r[`PSQ_QC_MODE_HI:`PSQ_QC_MODE_LO];
    wire [4:0] threshold_level = queue_control_r[`PSQ_QC_LEVEL_HI:`PSQ_QC_LEVEL_LO];
    wire queue_on = control_two_r[`PSQ_C2_QUEUE_ON];
    wire threshold_event_on = control_two_r[`PSQ_C2_THRESHOLD_ON];
    wire averaging_decimate_on = control_two_r[`PSQ_C2_DECIMATE_ON];
    wire mean_mode = queue_on && mode == `PSQ_MODE_AVERAGE && averaging_decimate_on;
    wire stream_mode = queue_on && (mode == `PSQ_MODE_STREAM
        || (mode == `PSQ_MODE_AVERAGE && !averaging_decimate_on));
    wire fill_mode = queue_on && mode == `PSQ_MODE_FILL_STOP;
    wire queue_used = fill_mode || stream_mode;
    wire [PTR_W:0] window = {{PTR_W{1'b0}}, 1'b1} << shift_nxt;
    wire [PTR_W:0] cap = mean_mode ? window : DEPTH_L;
    wire q_empty = (level_r == {(PTR_W+1){1'b0}});
    wire q_full = (level_r == DEPTH_L);
    wire wtm_hit = threshold_event_on && queue_used
        && level_r >= {1'b0, threshold_level};
    wire write_c2 = reg_wr && reg_addr == `PSQ_ADDR_CONTROL_TWO;
    wire write_qc = reg_wr && reg_addr == `PSQ_ADDR_QUEUE_CONTROL;
    wire flush = (write_qc && reg_wdata[`PSQ_QC_MODE_HI:`PSQ_QC_MODE_LO] != mode)
        || (write_c2 && !reg_wdata[`PSQ_C2_QUEUE_ON]);
    wire take = sample_valid && calib_done;
    wire read_upper = reg_rd && reg_addr == `PSQ_ADDR_PRESS_UPPER;
    wire pop = read_upper && queue_used && !q_empty;
    wire push = take && (mean_mode || stream_mode || (fill_mode && (!q_full || pop)));
    wire drop = push && level_r == cap && !pop;
    wire [23:0] head = mem[rd_ptr_r];
    wire [23:0] shown = (queue_used && !q_empty) ? head : out_hold_r;

    // ------------------------------------------------------------------------
    // Calibration copy after reset
    // ------------------------------------------------------------------------

    // Walks the calibration store once; samples are refused until it finishes.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cal_state_r <= CAL_LOAD;
            nvm_addr <= 3'h0;
            calib_done <= 1'b0;
        end else begin
            case (cal_state_r)
                CAL_LOAD: begin
                    nvm_addr <= nvm_addr + 3'h1;
                    if (nvm_addr == CAL_WORDS - 1) begin
                        cal_state_r <= CAL_RUN;
                        calib_done <= 1'b1;
                    end
                end
                CAL_RUN: begin
                    cal_state_r <= CAL_RUN;
                end
                default: begin
                    cal_state_r <= CAL_LOAD;
                end
            endcase
        end
    end

    // One working register per calibration word, loaded when its address is shown.
    genvar gi;
    generate
        for (gi = 0; gi < CAL_WORDS; gi = gi + 1) begin : g_trim
            always @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    trim_words[gi*8 +: 8] <= `PSQ_RST_BYTE;
                end else if (cal_state_r == CAL_LOAD && nvm_addr == gi) begin
                    trim_words[gi*8 +: 8] <= nvm_data;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------

    // Host writes to the control registers.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            control_two_r <= `PSQ_RST_BYTE;
            control_three_r <= `PSQ_RST_BYTE;
            control_four_r <= `PSQ_RST_BYTE;
            queue_control_r <= `PSQ_RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                `PSQ_ADDR_CONTROL_TWO: control_two_r <= reg_wdata;
                `PSQ_ADDR_CONTROL_THREE: control_three_r <= reg_wdata;
                `PSQ_ADDR_CONTROL_FOUR: control_four_r <= reg_wdata;
                `PSQ_ADDR_QUEUE_CONTROL: queue_control_r <= reg_wdata;
                default: control_two_r <= control_two_r;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Queue pointers, level and averaging sum
    // ------------------------------------------------------------------------

    // Averaging window is the largest power of two not above threshold plus one.
    always @* begin
        shift_nxt = 3'h0;
        if (threshold_level >= 5'h1F) begin
            shift_nxt = 3'h5;
        end else if (threshold_level >= 5'h0F) begin
            shift_nxt = 3'h4;
        end else if (threshold_level >= 5'h07) begin
            shift_nxt = 3'h3;
        end else if (threshold_level >= 5'h03) begin
            shift_nxt = 3'h2;
        end else if (threshold_level >= 5'h01) begin
            shift_nxt = 3'h1;
        end
    end

    // Next level and running sum for this cycle's push, pop and drop.
    always @* begin
        level_nxt = level_r;
        sum_nxt = sum_r;
        if (push && !(pop || drop)) begin
            level_nxt = level_r + {{PTR_W{1'b0}}, 1'b1};
        end else if (!push && pop) begin
            level_nxt = level_r - {{PTR_W{1'b0}}, 1'b1};
        end
        if (push && mean_mode) begin
            sum_nxt = sum_r + {{(PTR_W+1){1'b0}}, sample_press};
            if (drop) begin
                sum_nxt = sum_nxt - {{(PTR_W+1){1'b0}}, head};
            end
        end
    end

    // Pointer and level registers; a flush empties everything at once.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= {PTR_W{1'b0}};
            rd_ptr_r <= {PTR_W{1'b0}};
            level_r <= {(PTR_W+1){1'b0}};
            sum_r <= {(PTR_W+25){1'b0}};
        end else if (flush || !queue_on) begin
            wr_ptr_r <= {PTR_W{1'b0}};
            rd_ptr_r <= {PTR_W{1'b0}};
            level_r <= {(PTR_W+1){1'b0}};
            sum_r <= {(PTR_W+25){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            if (pop || drop) begin
                rd_ptr_r <= rd_ptr_r + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            level_r <= level_nxt;
            sum_r <= sum_nxt;
        end
    end

    // Slot storage, written at the write pointer.
    always @(posedge clock) begin
        if (push && !flush) begin
            mem[wr_ptr_r] <= sample_press;
        end
    end

    // ------------------------------------------------------------------------
    // Output result, new-result flag and interrupt
    // ------------------------------------------------------------------------

    // Latest result in bypass, or the average once a full window is held.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_hold_r <= 24'h000000;
        end else if (mean_mode) begin
            if (push && !flush && level_nxt == window) begin
                out_hold_r <= sum_nxt[23+shift_nxt -: 24];
            end
        end else if (take) begin
            out_hold_r <= sample_press;
        end
    end

    // New-result flag: a fresh pair sets it, reading the upper byte clears it.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_ready <= 1'b0;
        end else if (take) begin
            data_ready <= 1'b1;
        end else if (read_upper) begin
            data_ready <= 1'b0;
        end
    end

    // Routed conditions onto the pin, with selectable polarity.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_pin <= 1'b0;
        end else begin
            interrupt_pin <= control_three_r[`PSQ_C3_ACTIVE_LOW] ^ (
                (control_four_r[`PSQ_C4_ROUTE_READY] && data_ready)
                || (control_four_r[`PSQ_C4_ROUTE_THRESHOLD] && wtm_hit)
                || (control_four_r[`PSQ_C4_ROUTE_FULL] && q_full)
                || (control_four_r[`PSQ_C4_ROUTE_EMPTY] && q_empty));
        end
    end

    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------

    // Read data mux; pressure bytes show the oldest entry while a fill or stream queue holds one.
    always @* begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            `PSQ_ADDR_CONTROL_TWO: rdata_nxt = control_two_r;
            `PSQ_ADDR_CONTROL_THREE: rdata_nxt = control_three_r;
            `PSQ_ADDR_CONTROL_FOUR: rdata_nxt = control_four_r;
            `PSQ_ADDR_PRESS_LOWEST: rdata_nxt = shown[7:0];
            `PSQ_ADDR_PRESS_MIDDLE: rdata_nxt = shown[15:8];
            `PSQ_ADDR_PRESS_UPPER: rdata_nxt = shown[23:16];
            `PSQ_ADDR_QUEUE_CONTROL: rdata_nxt = queue_control_r;
            `PSQ_ADDR_QUEUE_STATUS: rdata_nxt = {wtm_hit, q_empty, level_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data is captured on the read strobe and held until the next read.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

endmodule // psq_queue

/* File: testbench/psq_cal_store.sv */
// Calibration store model on the trim load port of the queue.
// Assumes one address is shown at a time and read combinationally.
`timescale 1ns/10ps
module psq_cal_store (
    input wire [2:0] nvm_addr, // Store address.
    output wire [7:0] nvm_data // Byte at that address.
);
    // Every address holds a distinct byte so a misplaced copy shows.
    assign nvm_data = {nvm_addr, 5'h15} ^ 8'h3C;
endmodule // psq_cal_store

/* File: testbench/psq_queue_checker.sv */
// Port checker for the pressure sample queue.
// Assumes it is bound into every psq_queue instance.
`timescale 1ns/10ps
module psq_queue_checker #(
    parameter CAL_WORDS = 8 // Calibration words.
) (
    input wire clock, // System clock.
    input wire reset_n, // Reset, active low.
    input wire [6:0] reg_addr, // Register address.
    input wire reg_wr, // Write strobe.
    input wire [7:0] reg_wdata, // Write data.
    input wire reg_rd, // Read strobe.
    input wire [7:0] reg_rdata, // Read data.
    input wire sample_valid, // Sample pulse.
    input wire [2:0] nvm_addr, // Store address.
    input wire calib_done, // Calibration finished.
    input wire data_ready, // New result flag.
    input wire interrupt_pin // Interrupt output.
);
    reg pol_r;
    reg route_r;

    // Shadow the polarity and ready routing bits from host writes.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pol_r <= 1'b0;
            route_r <= 1'b0;
        end else if (reg_wr && reg_addr == 7'h22) begin
            pol_r <= reg_wdata[7];
        end else if (reg_wr && reg_addr == 7'h23) begin
            route_r <= reg_wdata[0];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_take;
        sample_valid && calib_done;
    endsequence
    sequence s_pop;
        reg_rd && reg_addr == 7'h2A && !sample_valid;
    endsequence

    AST_READY_SET: assert property (s_take |=> data_ready)
        else $error("ready flag missing after sample");
    AST_READY_CLR: assert property (s_pop |=> !data_ready)
        else $error("ready flag kept after upper byte read");
    AST_READY_HOLD: assert property (data_ready && !(reg_rd && reg_addr == 7'h2A) |=> data_ready)
        else $error("ready flag dropped without read");
    AST_EARLY: assert property (!calib_done |-> !data_ready)
        else $error("sample taken before calibration");
    AST_CAL_STICKY: assert property (calib_done |=> calib_done)
        else $error("calibration done fell");
    AST_CAL_STEP: assert property (!calib_done |=> calib_done || nvm_addr == $past(nvm_addr) + 3'h1)
        else $error("store address did not step");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    AST_UNMAPPED: assert property (reg_rd && reg_addr >= 7'h30 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_INT_READY: assert property (route_r && data_ready && !reg_wr |=> interrupt_pin != pol_r)
        else $error("interrupt not raised by ready");
endmodule // psq_queue_checker

bind psq_queue psq_queue_checker #(.CAL_WORDS(CAL_WORDS)) psq_queue_checker_inst (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .nvm_addr(nvm_addr), .calib_done(calib_done),
    .data_ready(data_ready), .interrupt_pin(interrupt_pin));

/* File: testbench/test_pressure_sample_queue.sv */
// Self-checking bench for the pressure sample queue.
// Assumes the checker binds itself and the store model feeds the trim port.
`timescale 1ns/10ps
module test_pressure_sample_queue;
    reg clock = 1'b0;
    reg reset_n = 1'b0;
    reg [6:0] reg_addr = 7'h00;
    reg reg_wr = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_rd = 1'b0;
    reg sample_valid = 1'b0;
    reg [23:0] sample_press = 24'h000000;
    wire [7:0] reg_rdata;
    wire [2:0] nvm_addr;
    wire [7:0] nvm_data;
    wire calib_done;
    wire [63:0] trim_words;
    wire data_ready;
    wire interrupt_pin;
    int failures = 0;
    int compares = 0;
    logic [31:0] seed = 32'h00010136;
    logic [7:0] expq[$];
    logic [23:0] mq[$];
    logic [6:0] cregs[4] = '{7'h21, 7'h22, 7'h23, 7'h2E};
    logic [2:0] mode = 3'h0;
    logic [63:0] trim_exp;
    logic [25:0] sum;
    logic rd_seen = 1'b0;

    psq_queue psq_queue_inst (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .sample_press(sample_press), .nvm_addr(nvm_addr),
        .nvm_data(nvm_data), .calib_done(calib_done), .trim_words(trim_words),
        .data_ready(data_ready), .interrupt_pin(interrupt_pin));
    psq_cal_store psq_cal_store_inst (.nvm_addr(nvm_addr), .nvm_data(nvm_data));

    // Clock at 50 MHz.
    always #10 clock = ~clock;

    function automatic [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // An idle edge follows each transfer, so a strobe is never lowered and raised at once.
    task automatic wr(input [6:0] a, input [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock);
        #1 reg_wr = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic rd(input [6:0] a, input [7:0] x);
        reg_addr = a;
        reg_rd = 1'b1;
        expq.push_back(x);
        @(posedge clock);
        #1 reg_rd = 1'b0;
        @(posedge clock);
        #1;
    endtask

    // One random sample; the expected queue keeps fill or stream order.
    task automatic rnd_smp();
        seed = lfsr(seed);
        sample_press = seed[23:0];
        sample_valid = 1'b1;
        if (mode == 3'h1 && mq.size() < 32) mq.push_back(seed[23:0]);
        if (mode == 3'h2) begin
            if (mq.size() == 32) void'(mq.pop_front());
            mq.push_back(seed[23:0]);
        end
        @(posedge clock);
        #1 sample_valid = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic rd3(input [23:0] v);
        rd(7'h28, v[7:0]);
        rd(7'h29, v[15:8]);
        rd(7'h2A, v[23:16]);
    endtask

    task automatic setq(input [2:0] m, input [4:0] lvl);
        mode = m;
        mq.delete();
        wr(7'h2E, {m, lvl});
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Read data is compared half a cycle after the edge that took the read.
    always @(posedge clock) rd_seen <= reg_rd;
    always @(negedge clock) if (rd_seen) check("reg_rdata", reg_rdata, expq.pop_front());

    // Watchdog for a hung run.
    initial begin
        #200000;
        failures++;
        final_report();
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge clock);
        #1 reset_n = 1'b1;
        for (int i = 0; i < 20 && calib_done !== 1'b1; i++) @(posedge clock);
        #1;
        for (int k = 0; k < 8; k++) trim_exp[8*k +: 8] = {k[2:0], 5'h15} ^ 8'h3C;
        check("trim_words", trim_words, trim_exp);
        foreach (cregs[i]) begin
            rd(cregs[i], 8'h00);
            seed = lfsr(seed);
            wr(cregs[i], seed[7:0]);
            rd(cregs[i], seed[7:0]);
        end
        rd(7'h30, 8'h00);
        rd(7'h7F, 8'h00);
        wr(7'h22, 8'h00);
        wr(7'h23, 8'h02);
        wr(7'h21, 8'h60);
        for (int m = 1; m < 3; m++) begin
            setq(m[2:0], 5'd5);
            rd(7'h2F, 8'h40);
            repeat (4) rnd_smp();
            rd(7'h2F, 8'h04);
            check("interrupt_pin", interrupt_pin, 1'b0);
            rnd_smp();
            rd(7'h2F, 8'h85);
            check("interrupt_pin", interrupt_pin, 1'b1);
            repeat (29) rnd_smp();
            rd(7'h2F, 8'hA0);
            wr(7'h23, 8'h04);
            check("interrupt_pin", interrupt_pin, 1'b1);
            wr(7'h23, 8'h02);
            repeat (32) rd3(mq.pop_front());
            rd(7'h2F, 8'h40);
        end
        repeat (3) rnd_smp();
        wr(7'h21, 8'h00);
        rd(7'h2F, 8'h40);
        wr(7'h21, 8'h40);
        repeat (2) rnd_smp();
        setq(3'h1, 5'd5);
        rd(7'h2F, 8'h40);
        setq(3'h0, 5'd0);
        wr(7'h23, 8'h01);
        rnd_smp();
        rd(7'h2F, 8'h40);
        check("interrupt_pin", interrupt_pin, 1'b1);
        rd3(seed[23:0]);
        wr(7'h22, 8'h80);
        @(posedge clock);
        #1 check("interrupt_pin", interrupt_pin, 1'b1);
        wr(7'h22, 8'h00);
        wr(7'h23, 8'h08);
        @(posedge clock);
        #1 check("interrupt_pin", interrupt_pin, 1'b1);
        wr(7'h23, 8'h00);
        wr(7'h21, 8'h50);
        setq(3'h6, 5'd3);
        // A window of four; the fifth sample pushes the oldest one out of the average.
        for (int j = 0; j < 5; j++) begin
            rnd_smp();
            mq.push_back(seed[23:0]);
            if (mq.size() > 4) void'(mq.pop_front());
            sum = 26'h0000000;
            foreach (mq[n]) sum = sum + {2'b00, mq[n]};
            if (j >= 3) rd3(sum[25:2]);
        end
        rd3(sum[25:2]);
        repeat (3) @(posedge clock);
        final_report();
    end
endmodule // test_pressure_sample_queue
